/* File: rtl/rtci_slave.sv */
// Purpose: two-wire slave port of a real-time clock module
// Assumes: bus pins are open drain, pulled up outside; reg_rdata follows
//          reg_raddr within one clock
// Notes:   both pins pass two flops; equal delay keeps their order
// What this block does
// - SDA fall with SCL high starts
// - SDA rise with SCL high stops
// - start inside transaction is repeated start
// - drive SDA only while SCL low
// - stop accepted anywhere, transaction aborted
// - 0.95 s transaction clears port to standby
// - after timeout, writes dropped, reads all ones
// - eight-bit bytes, MSB first, unlimited count
// - receiver drives ACK low on ninth clock
// - ACK released at ninth fall for data
// - master NACK: release SDA, await stop
// - answer only to address 0110010
// - address bit 0 selects direction
// - write: pointer byte, then data, all ACKed
// - pointer advances after each data byte
// - pointer wraps inside its 16-byte bank
// - addressed read via pointer write, repeated start
// - direct read continues after last address
// - calendar frozen during communication
`timescale 1ns/10ps
`include "rtci_map.svh"
module rtci_slave import rtci_pkg::*; #(
    parameter int TIMEOUT_CYC = `RTCI_TIMEOUT_MS * `RTCI_CLK_MHZ * 1000
) (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output wire logic       sda_out,
    output wire logic       sda_oe_n,
    output wire logic [7:0] reg_raddr,
    input  wire logic [7:0] reg_rdata,
    output wire logic [7:0] reg_waddr,
    output wire logic [7:0] reg_wdata,
    output wire logic       reg_we,
    output wire logic       freeze,
    output wire logic       bus_timeout
);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);

    rtci_pin_t   scl_ev;
    rtci_pin_t   sda_ev;
    rtci_state_t state_r;
    rtci_kind_t  kind_r;
    logic [3:0]  bitcnt_r;
    logic [7:0]  shift_r;
    logic        rw_r;
    logic        mack_r;
    logic        oe_n_r;
    logic [7:0]  ptr_r;
    logic [7:0]  waddr_r;
    logic [7:0]  wdata_r;
    logic        we_r;
    logic        freeze_r;
    logic        tmo_r;
    logic [TW-1:0] tmo_cnt_r;

    logic start_ev;
    logic stop_ev;
    logic tmo_hit;
    logic byte_done;
    logic addr_hit;
    logic load_tx;
    logic tx_done;
    logic ptr_adv;

    // next pointer, wrapping inside the 16-byte bank
    function automatic logic [7:0] ptr_inc(input logic [7:0] p);
        ptr_inc = {p[7:4], p[3:0] + 4'h1};
    endfunction

    // ============================================================
    // pin synchronisers
    rtci_pin_sync u_scl (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .pin     (scl_in),
        .ev      (scl_ev)
    );

    rtci_pin_sync u_sda (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .pin     (sda_in),
        .ev      (sda_ev)
    );

    // ============================================================
    // bus conditions and byte events
    assign start_ev  = sda_ev.fall & scl_ev.lvl;
    assign stop_ev   = sda_ev.rise & scl_ev.lvl;
    assign tmo_hit   = (state_r != ST_IDLE) && (tmo_cnt_r == TW'(TIMEOUT_CYC - 1));
    assign byte_done = (state_r == ST_RX) && scl_ev.fall && (bitcnt_r == `RTCI_BYTE_BITS);
    assign addr_hit  = (shift_r[7:1] == `RTCI_SLAVE_ADDR);
    assign load_tx   = scl_ev.fall && (((state_r == ST_RX_ACK) && (kind_r == K_ADDR)
                       && (rw_r == `RTCI_RW_READ)) || ((state_r == ST_TX_ACK) && mack_r));
    assign tx_done   = (state_r == ST_TX) && scl_ev.fall && (bitcnt_r == `RTCI_LAST_BIT);
    // a timed-out transfer must not move the pointer either
    assign ptr_adv   = ((byte_done && (kind_r == K_DATA)) || tx_done) && !tmo_hit;

    // ============================================================
    // port state machine; conditions override byte progress
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r  <= ST_IDLE;
            kind_r   <= K_ADDR;
            bitcnt_r <= 4'h0;
            shift_r  <= 8'h00;
            rw_r     <= 1'b0;
            mack_r   <= 1'b0;
            oe_n_r   <= 1'b1;
        end else begin
            case (state_r)
                ST_RX: begin
                    if (scl_ev.rise) begin
                        shift_r  <= {shift_r[6:0], sda_ev.lvl};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end else if (byte_done) begin
                        // unknown address: stay silent till the next condition
                        if (kind_r == K_ADDR && !addr_hit) begin
                            state_r <= ST_WAIT;
                        end else begin
                            state_r <= ST_RX_ACK;
                            oe_n_r  <= `RTCI_ACK_LEVEL;
                        end
                        if (kind_r == K_ADDR) begin
                            rw_r <= shift_r[0];
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (scl_ev.fall) begin
                        bitcnt_r <= 4'h0;
                        if (load_tx) begin
                            // first data bit goes out as the ACK ends
                            shift_r <= reg_rdata;
                            oe_n_r  <= reg_rdata[7];
                            state_r <= ST_TX;
                        end else begin
                            oe_n_r  <= 1'b1;
                            state_r <= ST_RX;
                            kind_r  <= (kind_r == K_ADDR) ? K_PTR : K_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (tx_done) begin
                        oe_n_r   <= 1'b1;
                        state_r  <= ST_TX_ACK;
                    end else if (scl_ev.fall) begin
                        shift_r  <= {shift_r[6:0], 1'b1};
                        oe_n_r   <= shift_r[6];
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end
                end
                ST_TX_ACK: begin
                    if (scl_ev.rise) begin
                        mack_r <= (sda_ev.lvl == `RTCI_ACK_LEVEL);
                    end else if (load_tx) begin
                        shift_r  <= reg_rdata;
                        oe_n_r   <= reg_rdata[7];
                        bitcnt_r <= 4'h0;
                        state_r  <= ST_TX;
                    end else if (scl_ev.fall) begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    oe_n_r <= 1'b1;
                end
                default: begin
                    oe_n_r <= 1'b1;
                end
            endcase
            // timeout and stop release the line at once
            if (tmo_hit) begin
                state_r <= ST_IDLE;
                oe_n_r  <= 1'b1;
            end
            if (stop_ev) begin
                state_r <= ST_IDLE;
                oe_n_r  <= 1'b1;
            end
            if (start_ev) begin
                state_r  <= ST_RX;
                kind_r   <= K_ADDR;
                bitcnt_r <= 4'h0;
                mack_r   <= 1'b0;
                oe_n_r   <= 1'b1;
            end
        end
    end

    // ============================================================
    // register pointer; kept across transactions for direct reads
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ptr_r <= `RTCI_PTR_RESET;
        end else if (byte_done && kind_r == K_PTR && !tmo_hit) begin
            ptr_r <= shift_r;
        end else if (ptr_adv) begin
            ptr_r <= ptr_inc(ptr_r);
        end
    end

    // ============================================================
    // write strobe; address held apart since the pointer moves on
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            we_r    <= 1'b0;
            waddr_r <= `RTCI_PTR_RESET;
            wdata_r <= 8'h00;
        end else begin
            we_r <= byte_done && (kind_r == K_DATA) && !tmo_hit;
            if (byte_done && kind_r == K_DATA) begin
                waddr_r <= ptr_r;
                wdata_r <= shift_r;
            end
        end
    end

    // ============================================================
    // transaction timer, started only by a start from standby
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tmo_cnt_r <= '0;
            tmo_r     <= 1'b0;
        end else begin
            tmo_r <= tmo_hit;
            if (start_ev && state_r == ST_IDLE) begin
                tmo_cnt_r <= '0;
            end else if (state_r != ST_IDLE && !tmo_hit) begin
                tmo_cnt_r <= tmo_cnt_r + TW'(1);
            end
        end
    end

    // calendar hold while the bus is busy; updates resume after
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            freeze_r <= 1'b0;
        end else begin
            freeze_r <= (state_r != ST_IDLE);
        end
    end

    // open drain: only ever pulls low
    assign sda_out     = 1'b0;
    assign sda_oe_n    = oe_n_r;
    assign reg_raddr   = ptr_r;
    assign reg_waddr   = waddr_r;
    assign reg_wdata   = wdata_r;
    assign reg_we      = we_r;
    assign freeze      = freeze_r;
    assign bus_timeout = tmo_r;

    // ============================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_start;
        start_ev;
    endsequence

    sequence s_opened;
        (state_r == ST_RX) && (kind_r == K_ADDR) && oe_n_r;
    endsequence

    property p_start_opens;
        s_start |=> s_opened;
    endproperty
    a_start_opens: assert property (p_start_opens) else $error("start not taken");

    property p_stop_closes;
        stop_ev && !start_ev |=> (state_r == ST_IDLE) && sda_oe_n;
    endproperty
    a_stop_closes: assert property (p_stop_closes) else $error("stop not taken");

    property p_drive_scl_low;
        $fell(oe_n_r) |-> !$past(scl_ev.lvl);
    endproperty
    a_drive_scl_low: assert property (p_drive_scl_low) else $error("sda driven in scl high");

    property p_timeout;
        tmo_hit && !start_ev |=> (state_r == ST_IDLE) && bus_timeout && sda_oe_n;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout did not clear");

    property p_no_late_write;
        reg_we |-> $past(state_r) == ST_RX && $past(kind_r) == K_DATA && !$past(tmo_hit);
    endproperty
    a_no_late_write: assert property (p_no_late_write) else $error("stray write");

    property p_foreign_addr;
        byte_done && kind_r == K_ADDR && !addr_hit && !start_ev && !stop_ev && !tmo_hit
            |=> (state_r == ST_WAIT) ##1 sda_oe_n;
    endproperty
    a_foreign_addr: assert property (p_foreign_addr) else $error("acked wrong address");

    property p_ptr_wrap;
        ptr_adv && !(byte_done && kind_r == K_PTR) |=> (reg_raddr[7:4] == $past(ptr_r[7:4]))
            && (reg_raddr[3:0] == 4'($past(ptr_r[3:0]) + 4'h1));
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer step wrong");

    sequence s_nack;
        (state_r == ST_TX_ACK) && scl_ev.fall && !mack_r && !start_ev && !stop_ev && !tmo_hit;
    endsequence

    property p_nack_release;
        s_nack |=> (state_r == ST_WAIT) && sda_oe_n;
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("drove after nack");

    property p_ack_low;
        state_r == ST_RX_ACK |-> !sda_oe_n;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack not driven");

    property p_freeze;
        s_start |=> ##1 freeze;
    endproperty
    a_freeze: assert property (p_freeze) else $error("no freeze on start");

endmodule

/* File: rtl/rtci_map.svh */
// Purpose: named constants of the clock module's two-wire slave port
// Assumes: included by bare name from every file that needs it
// Notes:   definitions only
`ifndef RTCI_MAP_SVH
`define RTCI_MAP_SVH

// ============================================================
// bus identity and framing
`define RTCI_SLAVE_ADDR   7'h32
`define RTCI_BYTE_BITS    4'h8
`define RTCI_LAST_BIT     4'h7
`define RTCI_RW_READ      1'h1
`define RTCI_ACK_LEVEL    1'h0
`define RTCI_PTR_RESET    8'h00

// ============================================================
// timing
`define RTCI_CLK_MHZ      250
`define RTCI_TIMEOUT_MS   950

`endif

/* File: rtl/rtci_pkg.sv */
// Purpose: shared types of the two-wire slave port
// Assumes: nothing
// Notes:   constants live in rtci_map.svh
package rtci_pkg;

    // ============================================================
    // synchronised pin with its edges
    typedef struct packed {
        logic lvl;
        logic rise;
        logic fall;
    } rtci_pin_t;

    // ============================================================
    // port states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RX     = 3'b001,
        ST_RX_ACK = 3'b010,
        ST_TX     = 3'b011,
        ST_TX_ACK = 3'b100,
        ST_WAIT   = 3'b101
    } rtci_state_t;

    // meaning of the byte being received
    typedef enum logic [1:0] {
        K_ADDR = 2'b00,
        K_PTR  = 2'b01,
        K_DATA = 2'b10
    } rtci_kind_t;

endpackage

/* File: rtl/rtci_pin_sync.sv */
// Purpose: two-flop synchroniser with edge finding for one bus pin
// Assumes: pin is asynchronous to sys_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module rtci_pin_sync import rtci_pkg::*; (
    input  wire logic      sys_clk,
    input  wire logic      sys_rst,
    input  wire logic      pin,
    output rtci_pin_t      ev
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // ============================================================
    // idle bus is high, so reset to high avoids a false edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign ev.lvl  = sync_r;
    assign ev.rise = sync_r & ~prev_r;
    assign ev.fall = ~sync_r & prev_r;
endmodule

/* File: testbench/rtci_bus_master.sv */
// Purpose: two-wire bus master model facing the slave port
// Assumes: open-drain lines, pull-ups resolved in the bench
// Notes:   every line change lands on a sys_clk falling edge
`timescale 1ns/10ps
module rtci_bus_master (
    input  wire logic sys_clk,
    input  wire logic sda_in,
    output logic      scl,
    output logic      sda_low
);
    // ============================================================
    // line control
    // idle bus: both lines released
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // wait n system clocks
    task automatic hc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // start or repeated start, only this side makes it
    task automatic start();
        sda_low = 1'b0;
        hc(5);
        scl = 1'b1;
        hc(10);
        sda_low = 1'b1;
        hc(10);
        scl = 1'b0;
        hc(5);
    endtask

    // stop, then a free gap just over 1.3 us
    task automatic stop();
        sda_low = 1'b1;
        hc(5);
        scl = 1'b1;
        hc(10);
        sda_low = 1'b0;
        hc(330);
    endtask

    // ============================================================
    // bit and byte transfers
    // data moves only while scl low, sampled mid-high
    task automatic bit_xfer(input logic v, output logic s);
        sda_low = ~v;
        hc(5);
        scl = 1'b1;
        hc(5);
        s = sda_in;
        hc(5);
        scl = 1'b0;
        hc(5);
    endtask

    // msb first, ninth clock released for the ack
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask

    // ack the wanted bytes, nack the last one
    task automatic get_byte(output logic [7:0] b, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            b[i] = s;
        end
        bit_xfer(~ack, s);
    endtask
endmodule

/* File: testbench/testbench.sv */
// Purpose: self-checking bench of the two-wire slave port
// Assumes: backing registers modelled here as a plain array
// Notes:   timeout shortened to TO_CYC clocks
`timescale 1ns/10ps
module testbench;
    localparam int TO_CYC = 2000;
    logic       sys_clk;
    logic       sys_rst;
    logic       scl;
    logic       m_low;
    logic       sda;
    logic       sda_out;
    logic       sda_oe_n;
    logic [7:0] reg_raddr;
    logic [7:0] reg_waddr;
    logic [7:0] reg_wdata;
    logic       reg_we;
    logic       freeze;
    logic       bus_timeout;
    logic [7:0] mem [0:255];
    int         we_cnt      = 0;
    int         to_cnt      = 0;
    int         err_count   = 0;
    int         checks_done = 0;

    // ============================================================
    // clock, wire and backing registers
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // open drain with pull-up: either party may pull low
    assign sda = !(m_low || (!sda_oe_n && !sda_out));

    function automatic logic [7:0] init_val(input logic [7:0] a);
        return a ^ 8'hA5;
    endfunction

    // writes land at the edge of the pulse; pulses counted
    always @(posedge sys_clk) begin
        if (reg_we === 1'b1) begin
            mem[reg_waddr] <= reg_wdata;
            we_cnt <= we_cnt + 1;
        end
        if (bus_timeout === 1'b1) to_cnt <= to_cnt + 1;
    end

    rtci_slave #(.TIMEOUT_CYC(TO_CYC)) u_dut (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .scl_in      (scl),
        .sda_in      (sda),
        .sda_out     (sda_out),
        .sda_oe_n    (sda_oe_n),
        .reg_raddr   (reg_raddr),
        .reg_rdata   (mem[reg_raddr]),
        .reg_waddr   (reg_waddr),
        .reg_wdata   (reg_wdata),
        .reg_we      (reg_we),
        .freeze      (freeze),
        .bus_timeout (bus_timeout)
    );

    rtci_bus_master u_mst (
        .sys_clk (sys_clk),
        .sda_in  (sda),
        .scl     (scl),
        .sda_low (m_low)
    );

    // ============================================================
    // checking and closing
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ============================================================
    // scenarios
    // write across the bank wrap 0E, 0F, 00
    task automatic t_write();
        logic       a;
        logic [7:0] wd [3];
        logic [7:0] ad;
        int         n0;
        wd = '{8'hA5, 8'h5A, 8'hC3};
        n0 = we_cnt;
        u_mst.start();
        u_mst.put_byte(8'h64, a);
        check({7'h00, a}, 8'h01);
        check({7'h00, freeze}, 8'h01);
        u_mst.put_byte(8'h0E, a);
        check({7'h00, a}, 8'h01);
        for (int i = 0; i < 3; i++) begin
            u_mst.put_byte(wd[i], a);
            check({7'h00, a}, 8'h01);
        end
        u_mst.stop();
        for (int i = 0; i < 3; i++) begin
            ad = {4'h0, 4'(4'hE + i)};
            check(mem[ad], wd[i]);
        end
        check(8'(we_cnt - n0), 8'h03);
        check({7'h00, freeze}, 8'h00);
        $display("test write done");
    endtask

    // pointer write, repeated start, read across 1F -> 10
    task automatic t_addr_read();
        logic       a;
        logic       s;
        logic [7:0] b;
        u_mst.start();
        u_mst.put_byte(8'h64, a);
        u_mst.put_byte(8'h1E, a);
        u_mst.start();
        check({7'h00, freeze}, 8'h01);
        u_mst.put_byte(8'h65, a);
        check({7'h00, a}, 8'h01);
        for (int i = 0; i < 3; i++) begin
            u_mst.get_byte(b, i < 2);
            check(b, init_val({4'h1, 4'(4'hE + i)}));
        end
        check({7'h00, sda_oe_n}, 8'h01);
        // two more clocks: a wrongly sent next byte would show its 0 bit
        repeat (2) u_mst.bit_xfer(1'b1, s);
        check({7'h00, s}, 8'h01);
        u_mst.stop();
        $display("test addressed read done");
    endtask

    // direct read goes on after the last address, 10 -> 11
    task automatic t_direct_read();
        logic       a;
        logic [7:0] b;
        u_mst.start();
        u_mst.put_byte(8'h65, a);
        check({7'h00, a}, 8'h01);
        u_mst.get_byte(b, 1'b0);
        check(b, init_val(8'h11));
        u_mst.stop();
        $display("test direct read done");
    endtask

    // foreign addresses: no ack, no write
    task automatic t_foreign();
        logic       a;
        logic [7:0] fa [3];
        int         n0;
        fa = '{8'h66, 8'hE4, 8'h24};
        n0 = we_cnt;
        for (int i = 0; i < 3; i++) begin
            u_mst.start();
            u_mst.put_byte(fa[i], a);
            check({7'h00, a}, 8'h00);
            u_mst.put_byte(8'h00, a);
            check({7'h00, a}, 8'h00);
            u_mst.stop();
        end
        check(8'(we_cnt - n0), 8'h00);
        $display("test foreign address done");
    endtask

    // stop in mid data byte drops the partial byte
    task automatic t_abort();
        logic a;
        logic s;
        int   n0;
        n0 = we_cnt;
        u_mst.start();
        u_mst.put_byte(8'h64, a);
        u_mst.put_byte(8'h05, a);
        repeat (4) u_mst.bit_xfer(1'b0, s);
        u_mst.stop();
        check(8'(we_cnt - n0), 8'h00);
        check(mem[8'h05], init_val(8'h05));
        check({7'h00, freeze}, 8'h00);
        $display("test abort done");
    endtask

    // transactions held past the limit on purpose
    task automatic t_timeout();
        logic       a;
        logic [7:0] b;
        int         n0;
        n0 = we_cnt;
        u_mst.start();
        u_mst.put_byte(8'h65, a);
        u_mst.hc(TO_CYC + 100);
        check(8'(to_cnt), 8'h01);
        check({7'h00, freeze}, 8'h00);
        u_mst.get_byte(b, 1'b0);
        check(b, 8'hFF);
        u_mst.stop();
        u_mst.start();
        u_mst.put_byte(8'h64, a);
        u_mst.put_byte(8'h03, a);
        u_mst.hc(TO_CYC + 100);
        u_mst.put_byte(8'h77, a);
        check({7'h00, a}, 8'h00);
        u_mst.stop();
        check(8'(to_cnt), 8'h02);
        check(8'(we_cnt - n0), 8'h00);
        check(mem[8'h03], init_val(8'h03));
        $display("test timeout done");
    endtask

    // ============================================================
    // main sequence and watchdog
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = init_val(8'(i));
        sys_rst = 1'b1;
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (10) @(negedge sys_clk);
        t_write();
        t_addr_read();
        t_direct_read();
        t_foreign();
        t_abort();
        t_timeout();
        test_done();
    end

    // cuts a hang short; counts as a mismatch
    initial begin
        repeat (90000) @(posedge sys_clk);
        err_count++;
        $display("watchdog expired at %0t", $time);
        test_done();
    end
endmodule
